// [core/ieih_ctrl.sv]
/*
 * external interrupt controller: one pin source, flag, request to the
 * cpu core, vector supply, and the documented hazards.
 * assumes: all inputs but ext_pin come from logic on clock; the cpu core
 * keeps the software sequences that avoid the hazards.
 */
// What this block does
// - config register access blanks edge detection for each clock cycle that port_cfg_access is high.
// - an edge during the blanked cycle is lost, no request raised.
// - request arriving during flags restore yields reset vector, not source vector.
// - request active while its flag is cleared gives unwanted reset.
// - clearing the source enable never gives an unwanted reset.

`timescale 1ns/10ps

module ieih_ctrl #(
   parameter logic [15:0] RESET_VEC = ieih_pkg::IEIH_RESET_VEC,
   parameter logic [15:0] EXT_VEC = ieih_pkg::IEIH_EXT_VEC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ext_pin,
   input wire logic port_cfg_access,
   input wire ieih_pkg::ieih_sens_t pin_sense,
   input wire logic src_enable,
   input wire logic global_mask,
   input wire logic flag_clear,
   input wire logic flags_pop_active,
   input wire logic cpu_ack,
   input wire logic service_return,
   output logic irq_req_ff,
   output logic [15:0] vector_ff,
   output logic vector_valid_ff,
   output logic unwanted_rst_ff,
   output logic flag_ff,
   output logic in_service_ff
);
   // --------------------------------------------------------------
   // edge detector
   // --------------------------------------------------------------
   logic edge_ff;

   ieih_edge u_edge (
      .clock(clock),
      .rst(rst),
      .pin_in(ext_pin),
      .cfg_access(port_cfg_access),
      .sens(pin_sense),
      .edge_ff(edge_ff)
   );

   // --------------------------------------------------------------
   // flag, request and service state
   // --------------------------------------------------------------
   ieih_pkg::ieih_state_t state_ff, nxt_state;
   logic lost_src_ff, nxt_lost_src;
   logic nxt_flag, nxt_irq, nxt_valid, nxt_unwanted, nxt_in_service;
   logic [15:0] nxt_vector;
   logic active;

   always_comb begin
      nxt_state = state_ff;
      nxt_flag = edge_ff | (flag_ff & ~flag_clear);
      active = flag_ff & src_enable & ~global_mask;
      nxt_irq = 1'b0;
      nxt_lost_src = lost_src_ff;
      nxt_vector = vector_ff;
      nxt_valid = 1'b0;
      // only the flag clear can hit; the enable bit has no path here
      nxt_unwanted = 1'b0;
      case (state_ff)
         ieih_pkg::IEIH_ST_IDLE: begin
            nxt_irq = active & ~cpu_ack;
            if (flag_clear && irq_req_ff) begin
               nxt_unwanted = 1'b1;
            end
            if (nxt_irq && !irq_req_ff && flags_pop_active) begin
               nxt_lost_src = 1'b1;
            end
            if (cpu_ack) begin
               nxt_vector = lost_src_ff ? RESET_VEC : EXT_VEC;
               nxt_valid = 1'b1;
               nxt_lost_src = 1'b0;
               nxt_state = ieih_pkg::IEIH_ST_SERV;
            end
         end
         ieih_pkg::IEIH_ST_SERV: begin
            if (service_return) begin
               nxt_state = ieih_pkg::IEIH_ST_IDLE;
            end
         end
         default: begin
            nxt_state = ieih_pkg::IEIH_ST_IDLE;
         end
      endcase
      nxt_in_service = (nxt_state == ieih_pkg::IEIH_ST_SERV);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= ieih_pkg::IEIH_ST_IDLE;
         flag_ff <= 1'b0;
         irq_req_ff <= 1'b0;
         lost_src_ff <= 1'b0;
         vector_ff <= 16'h0000;
         vector_valid_ff <= 1'b0;
         unwanted_rst_ff <= 1'b0;
         in_service_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         flag_ff <= nxt_flag;
         irq_req_ff <= nxt_irq;
         lost_src_ff <= nxt_lost_src;
         vector_ff <= nxt_vector;
         vector_valid_ff <= nxt_valid;
         unwanted_rst_ff <= nxt_unwanted;
         in_service_ff <= nxt_in_service;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_req_in_pop;
      !irq_req_ff && flags_pop_active && !in_service_ff
         && flag_ff && src_enable && !global_mask && !cpu_ack;
   endsequence

   sequence s_first_ack;
      !cpu_ack [*1] ##1 cpu_ack;
   endsequence

   property p_bad_vector;
      s_req_in_pop ##2 (cpu_ack && !in_service_ff) |=> vector_valid_ff
         && vector_ff == RESET_VEC;
   endproperty
   a_bad_vector: assert property (p_bad_vector) else $error("reset vector not given");

   property p_good_vector;
      (cpu_ack && !in_service_ff && !lost_src_ff) |=> vector_valid_ff && vector_ff == EXT_VEC;
   endproperty
   a_good_vector: assert property (p_good_vector) else $error("source vector wrong");

   property p_unwanted;
      (flag_clear && irq_req_ff && !in_service_ff) |=> unwanted_rst_ff ##1 !unwanted_rst_ff
         || $past(flag_clear && irq_req_ff);
   endproperty
   a_unwanted: assert property (p_unwanted) else $error("hazard reset missing");

   property p_no_mask_reset;
      unwanted_rst_ff |-> $past(flag_clear) && $past(irq_req_ff);
   endproperty
   a_no_mask_reset: assert property (p_no_mask_reset) else $error("reset without flag clear");

   property p_flag_set;
      edge_ff |=> flag_ff;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");

   property p_req_follows;
      (edge_ff && src_enable && !global_mask && !in_service_ff && !cpu_ack)
         ##1 (src_enable && !global_mask && !cpu_ack && !in_service_ff) |=> irq_req_ff;
   endproperty
   a_req_follows: assert property (p_req_follows) else $error("request not raised");

   property p_blank_no_flag;
      (port_cfg_access && !flag_ff && !edge_ff) |=> !edge_ff ##1 (flag_ff == $past(edge_ff));
   endproperty
   a_blank_no_flag: assert property (p_blank_no_flag) else $error("blanked edge set flag");
endmodule

// [core/ieih_edge.sv]
/*
 * package of shared constants and types, plus the blanked edge detector
 * for one external interrupt pin.
 * assumes: pin_in is asynchronous; cfg_access comes from logic on clock.
 */

package ieih_pkg;
   // --------------------------------------------------------------
   // sensitivity and vectors
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      IEIH_SENS_FALL = 2'b00,
      IEIH_SENS_RISE = 2'b01,
      IEIH_SENS_BOTH = 2'b10,
      IEIH_SENS_NONE = 2'b11
   } ieih_sens_t;

   typedef enum logic [0:0] {
      IEIH_ST_IDLE = 1'b0,
      IEIH_ST_SERV = 1'b1
   } ieih_state_t;

   localparam int IEIH_VEC_W = 16;
   // vector values arbitrary
   localparam logic [15:0] IEIH_RESET_VEC = 16'h1000;
   localparam logic [15:0] IEIH_EXT_VEC = 16'h1010;
   localparam logic IEIH_SYNC_RST = 1'b1;
endpackage

`timescale 1ns/10ps

module ieih_edge (
   input wire logic clock,
   input wire logic rst,
   input wire logic pin_in,
   input wire logic cfg_access,
   input wire ieih_pkg::ieih_sens_t sens,
   output logic edge_ff
);
   // --------------------------------------------------------------
   // edge match
   // --------------------------------------------------------------
   function automatic logic edge_hit(input ieih_pkg::ieih_sens_t s, input logic prv,
                                     input logic cur);
      case (s)
         ieih_pkg::IEIH_SENS_FALL: edge_hit = prv & ~cur;
         ieih_pkg::IEIH_SENS_RISE: edge_hit = ~prv & cur;
         ieih_pkg::IEIH_SENS_BOTH: edge_hit = prv ^ cur;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   logic sync1_ff, sync2_ff, prev_ff;
   logic nxt_sync1, nxt_sync2, nxt_prev, nxt_edge, hit;

   // --------------------------------------------------------------
   // synchroniser and detector
   // --------------------------------------------------------------
   always_comb begin
      nxt_sync1 = pin_in;
      nxt_sync2 = sync1_ff;
      nxt_prev = sync2_ff;
      hit = edge_hit(sens, prev_ff, sync2_ff);
      nxt_edge = hit & ~cfg_access;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_ff <= ieih_pkg::IEIH_SYNC_RST;
         sync2_ff <= ieih_pkg::IEIH_SYNC_RST;
         prev_ff <= ieih_pkg::IEIH_SYNC_RST;
         edge_ff <= 1'b0;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         prev_ff <= nxt_prev;
         edge_ff <= nxt_edge;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_blank;
      cfg_access |=> !edge_ff;
   endproperty
   a_blank: assert property (p_blank) else $error("edge seen during config access");

   property p_lost;
      (cfg_access && hit) |=> !edge_ff ##1 !edge_ff || (prev_ff != $past(prev_ff));
   endproperty
   a_lost: assert property (p_lost) else $error("blanked edge reported later");

   property p_detect;
      (!cfg_access && hit) |=> edge_ff;
   endproperty
   a_detect: assert property (p_detect) else $error("unblanked edge missed");
endmodule

// [sim/ieih_cpu_model.sv]
/*
 * cpu core partner: takes requests and runs a short service routine.
 * assumes: all signals on clock; auto_ack lets the model take requests.
 */
`timescale 1ns/10ps
module ieih_cpu_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic auto_ack,
   input wire logic irq_req,
   input wire logic in_service,
   output logic cpu_ack,
   output logic service_return,
   output logic flag_clear
);
   logic [2:0] step_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cpu_ack <= 1'b0;
         service_return <= 1'b0;
         flag_clear <= 1'b0;
         step_ff <= 3'h0;
      end else begin
         cpu_ack <= auto_ack && irq_req && !cpu_ack && !in_service;
         step_ff <= in_service ? step_ff + 3'h1 : 3'h0;
         flag_clear <= in_service && (step_ff == 3'h1);
         service_return <= in_service && (step_ff == 3'h3);
      end
   end
endmodule

// [sim/ieih_ctrl_test.sv]
/*
 * bench for ieih_ctrl: edge table, blanking, vectors and flag hazards.
 * assumes: ieih_cpu_model takes requests and clears the flag in service.
 */
`timescale 1ns/10ps
module ieih_ctrl_test;
   typedef struct {ieih_pkg::ieih_sens_t s; logic from; logic exp;} ieih_row_t;
   logic clock = 0, rst = 1, pin = 1, cfg = 0, src_en = 0, gmask = 0;
   logic tb_clr = 0, pop = 0, auto_ack = 0, cpu_ack, svc_ret, m_clr;
   logic irq, vv, urst, flag, insvc, sema = 0, lvl_pre = 0;
   logic [15:0] vec, last_vec = 16'h0000;
   ieih_pkg::ieih_sens_t sens = ieih_pkg::IEIH_SENS_FALL;
   int n_fail = 0, n_tests = 0, n_urst = 0, n_vv = 0;
   ieih_row_t rows[5] = '{'{ieih_pkg::IEIH_SENS_FALL, 1'b1, 1'b1},
      '{ieih_pkg::IEIH_SENS_FALL, 1'b0, 1'b0}, '{ieih_pkg::IEIH_SENS_RISE, 1'b0, 1'b1},
      '{ieih_pkg::IEIH_SENS_BOTH, 1'b0, 1'b1}, '{ieih_pkg::IEIH_SENS_NONE, 1'b1, 1'b0}};
   always #20 clock = ~clock;
   always @(posedge clock) begin
      if (urst === 1'b1) n_urst++;
      if (vv === 1'b1) begin
         n_vv++;
         last_vec = vec;
      end
   end
   ieih_ctrl ieih_ctrl_inst (.clock(clock), .rst(rst), .ext_pin(pin),
      .port_cfg_access(cfg), .pin_sense(sens), .src_enable(src_en), .global_mask(gmask),
      .flag_clear(tb_clr | m_clr), .flags_pop_active(pop), .cpu_ack(cpu_ack),
      .service_return(svc_ret), .irq_req_ff(irq), .vector_ff(vec), .vector_valid_ff(vv),
      .unwanted_rst_ff(urst), .flag_ff(flag), .in_service_ff(insvc));
   ieih_cpu_model ieih_cpu_model_inst (.clock(clock), .rst(rst), .auto_ack(auto_ack),
      .irq_req(irq), .in_service(insvc), .cpu_ack(cpu_ack), .service_return(svc_ret),
      .flag_clear(m_clr));
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic clr();
      @(posedge clock) tb_clr <= 1'b1;
      @(posedge clock) tb_clr <= 1'b0;
   endtask
   task automatic edge_fall();
      pin <= 1'b1;
      cyc(3);
      pin <= 1'b0;
      cyc(7);
   endtask
   task automatic summarize();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #40000;
      n_fail++;
      summarize();
   end
   initial begin
      cyc(5);
      rst <= 1'b0;
      cyc(2);
      check({11'h000, irq, vv, urst, flag, insvc}, 16'h0000);
      foreach (rows[i]) begin
         sens <= rows[i].s;
         pin <= rows[i].from;
         cyc(8);
         clr();
         cyc(2);
         pin <= ~rows[i].from;
         cyc(7);
         check(16'(flag), 16'(rows[i].exp));
      end
      sens <= ieih_pkg::IEIH_SENS_FALL;
      pin <= 1'b1;
      cyc(8);
      sema = 1'b1;
      lvl_pre = pin;
      pin <= 1'b0;
      cfg <= 1'b1;
      cyc(4);
      cfg <= 1'b0;
      cyc(6);
      check(16'(flag), 16'h0000);
      sema = sema & ~flag;
      check(16'({sema, lvl_pre, pin}), 16'h0006);
      cfg <= 1'b1;
      cyc(1);
      cfg <= 1'b0;
      edge_fall();
      check(16'(flag), 16'h0001);
      src_en <= 1'b1;
      auto_ack <= 1'b1;
      cyc(12);
      check(last_vec, ieih_pkg::IEIH_EXT_VEC);
      check(16'({flag, insvc, 6'(n_urst)}), 16'h0000);
      pop <= 1'b1;
      edge_fall();
      pop <= 1'b0;
      cyc(10);
      check(last_vec, ieih_pkg::IEIH_RESET_VEC);
      gmask <= 1'b1;
      pop <= 1'b1;
      edge_fall();
      pop <= 1'b0;
      gmask <= 1'b0;
      cyc(12);
      check(last_vec, ieih_pkg::IEIH_EXT_VEC);
      check(16'(n_vv), 16'h0003);
      auto_ack <= 1'b0;
      edge_fall();
      check(16'(irq), 16'h0001);
      clr();
      cyc(2);
      check(16'(n_urst), 16'h0001);
      edge_fall();
      src_en <= 1'b0;
      cyc(3);
      src_en <= 1'b1;
      cyc(3);
      check(16'(n_urst), 16'h0001);
      gmask <= 1'b1;
      cyc(2);
      clr();
      gmask <= 1'b0;
      cyc(3);
      check(16'({flag, 7'(n_urst)}), 16'h0001);
      summarize();
   end
endmodule
